// file: hdl/cmsl_pkg.sv
// Shared constants, types and mode decoding for the configuration loader.
`default_nettype none
package cmsl_pkg;
	// ==================================================================
	// Loading methods and controller states
	typedef enum logic [1:0] {
		CMSL_M_MASTER = 2'h0,
		CMSL_M_SCAN = 2'h1,
		CMSL_M_BYTE = 2'h2,
		CMSL_M_SLAVE = 2'h3
	} cmsl_method_e;
	typedef enum logic [1:0] {
		CMSL_ST_CLEAR = 2'h0,
		CMSL_ST_LOAD = 2'h1,
		CMSL_ST_DONE = 2'h3
	} cmsl_state_e;
	// ==================================================================
	// Mode-select codes {bit2, bit1, bit0}
	localparam logic [2:0] CMSL_CODE_MASTER_FLOAT = 3'h0;
	localparam logic [2:0] CMSL_CODE_SCAN_PULL = 3'h1;
	localparam logic [2:0] CMSL_CODE_BYTE_PULL = 3'h2;
	localparam logic [2:0] CMSL_CODE_SLAVE_PULL = 3'h3;
	localparam logic [2:0] CMSL_CODE_MASTER_PULL = 3'h4;
	localparam logic [2:0] CMSL_CODE_SCAN_FLOAT = 3'h5;
	localparam logic [2:0] CMSL_CODE_BYTE_FLOAT = 3'h6;
	localparam logic [2:0] CMSL_CODE_SLAVE_FLOAT = 3'h7;
	// ==================================================================
	// Widths, sizes and timing
	localparam int CMSL_BYTE_W = 8;
	localparam int CMSL_CFG_BITS = 256;
	localparam int CMSL_CLK_MHZ = 100;
	localparam int CMSL_INIT_CLR_NS = 200;
	localparam int CMSL_INIT_CLR_CYC = (CMSL_INIT_CLR_NS * CMSL_CLK_MHZ + 999) / 1000;
	localparam int CMSL_CFG_BIT_CLOCK_HALF_NS = 30;
	localparam int CMSL_CFG_BIT_CLOCK_HALF_CYC = (CMSL_CFG_BIT_CLOCK_HALF_NS * CMSL_CLK_MHZ) / 1000;
	localparam logic [2:0] CMSL_NBIT_LAST = 3'h7;
	// ==================================================================
	// Pull-up option per code, exactly as the code table assigns it
	function automatic logic cmsl_pullup(input logic [2:0] code);
		logic p;
		p = 1'b0;
		unique case (code)
			CMSL_CODE_MASTER_PULL, CMSL_CODE_SCAN_PULL, CMSL_CODE_BYTE_PULL, CMSL_CODE_SLAVE_PULL: p = 1'b1;
			default: p = 1'b0;
		endcase
		return p;
	endfunction
	// Method from the two low code bits
	function automatic cmsl_method_e cmsl_method(input logic [2:0] code);
		return cmsl_method_e'(code[1:0]);
	endfunction
endpackage
`default_nettype wire

// file: hdl/cmsl_loader.sv
// Configuration loader: mode decode, serial/byte/scan loading and daisy-chain forwarding.
// Notes on behaviour
// - Three mode pins pick one of four loading methods, each with pull-up option.
// - Code 000 is master serial, floating; device drives the bit clock, forwards data.
// - Code 110 is byte-parallel, floating; bit clock is input, no forwarding output.
// - Codes 111 and 011 select slave serial; clock input, one bit, forwarding.
// - An undriven mode pin reads high, so undriven pins give slave serial.
// - Scan-port loading always works; scan code only switches other methods off.
// - After own loading completes, further incoming bits pass to the forwarding output.
// - Forwarding output changes on the rising bit clock edge only.
// - After loading, unused I/O is tristate with weak pull-down; shared pins freed.
`default_nettype none
module cmsl_loader #(
	parameter int CFG_BITS = cmsl_pkg::CMSL_CFG_BITS,
	parameter int INIT_CLR_CYC = cmsl_pkg::CMSL_INIT_CLR_CYC,
	parameter int CFG_BIT_CLOCK_HALF_CYC = cmsl_pkg::CMSL_CFG_BIT_CLOCK_HALF_CYC
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic mode_sel_bit2_i,
	input wire logic mode_sel_bit2_driven_i,
	input wire logic mode_sel_bit1_i,
	input wire logic mode_sel_bit1_driven_i,
	input wire logic mode_sel_bit0_i,
	input wire logic mode_sel_bit0_driven_i,
	input wire logic reconfig_req_n_i,
	input wire logic cfg_bit_clock_i,
	output logic cfg_bit_clock_o,
	output logic cfg_bit_clock_oe_o,
	input wire logic ser_data_i,
	output logic ser_fwd_o,
	output logic ser_fwd_oe_o,
	input wire logic [cmsl_pkg::CMSL_BYTE_W-1:0] byte_data_i,
	input wire logic byte_wr_en_i,
	input wire logic scan_bit_i,
	input wire logic scan_bit_valid_i,
	output logic init_ready_o,
	output logic done_o,
	output logic [1:0] load_method_o,
	output logic io_pullup_en_o,
	output logic unused_io_pulldown_o,
	output logic shared_pins_free_o,
	output logic [cmsl_pkg::CMSL_BYTE_W-1:0] cfg_byte_o,
	output logic cfg_byte_valid_o
);
	import cmsl_pkg::*;
	localparam int CW = $clog2(CFG_BITS + CMSL_BYTE_W) + 1;
	localparam logic [CW-1:0] CFG_BITS_C = CW'(CFG_BITS);
	localparam logic [CW-1:0] BYTE_STEP_C = CW'(CMSL_BYTE_W);
	localparam int DW = $clog2(CFG_BIT_CLOCK_HALF_CYC + 1) + 1;
	localparam int RW = $clog2(INIT_CLR_CYC + 1) + 1;
	localparam logic [DW-1:0] HALF_LAST_C = DW'(CFG_BIT_CLOCK_HALF_CYC - 1);
	localparam logic [RW-1:0] CLR_LAST_C = RW'(INIT_CLR_CYC - 1);
	// ==================================================================
	// Pin synchronisers in the system domain
	// Reset value matches idle pins, so a short clear cannot latch a false mode from the flops
	localparam logic [8:0] PIN_RST_C = 9'h047;
	logic lk_done_reg;
	logic lk_tgl_reg;
	logic [8:0] pin_meta_reg;
	logic [8:0] pin_sync_reg;
	logic tgl_seen_reg;
	// Order: {byte toggle, link done, request, mode drive flags, mode levels}
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			pin_meta_reg <= PIN_RST_C;
			pin_sync_reg <= PIN_RST_C;
			tgl_seen_reg <= 1'b0;
		end else begin
			pin_meta_reg <= {lk_tgl_reg, lk_done_reg, reconfig_req_n_i, mode_sel_bit2_driven_i,
				mode_sel_bit1_driven_i, mode_sel_bit0_driven_i, mode_sel_bit2_i, mode_sel_bit1_i, mode_sel_bit0_i};
			pin_sync_reg <= pin_meta_reg;
			tgl_seen_reg <= pin_sync_reg[8];
		end
	end
	logic [2:0] mode_sync;
	logic req_n_sync;
	logic lk_done_sync;
	logic lk_byte_evt;
	// Undriven mode pins read high, standing in for the internal pull-ups
	assign mode_sync = pin_sync_reg[2:0] | ~pin_sync_reg[5:3];
	assign req_n_sync = pin_sync_reg[6];
	assign lk_done_sync = pin_sync_reg[7];
	assign lk_byte_evt = pin_sync_reg[8] ^ tgl_seen_reg;
	// ==================================================================
	// Controller: clear, load, done
	cmsl_state_e state_reg, state_next;
	logic [RW-1:0] clr_cnt_reg, clr_cnt_next;
	cmsl_method_e method_reg, method_next;
	logic pullup_reg, pullup_next;
	logic clr_reg, clr_next;
	logic sc_done_reg;
	// Next controller state
	always_comb begin
		state_next = state_reg;
		clr_cnt_next = clr_cnt_reg;
		method_next = method_reg;
		pullup_next = pullup_reg;
		unique case (state_reg)
			CMSL_ST_CLEAR: begin
				if (clr_cnt_reg != CLR_LAST_C) begin
					clr_cnt_next = clr_cnt_reg + RW'(1);
				end else if (req_n_sync) begin
					// Mode caught once per cycle, pins ignored afterwards
					method_next = cmsl_method(mode_sync);
					pullup_next = cmsl_pullup(mode_sync);
					state_next = CMSL_ST_LOAD;
				end
			end
			CMSL_ST_LOAD: begin
				if (sc_done_reg || lk_done_sync) begin
					state_next = CMSL_ST_DONE;
				end
			end
			CMSL_ST_DONE: begin
				state_next = CMSL_ST_DONE;
			end
			default: begin
				state_next = CMSL_ST_CLEAR;
			end
		endcase
		// A low request restarts from any state
		if (!req_n_sync) begin
			state_next = CMSL_ST_CLEAR;
			clr_cnt_next = '0;
		end
		// Hold link logic in reset while clearing
		clr_next = (state_next == CMSL_ST_CLEAR);
	end
	// Controller registers
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			state_reg <= CMSL_ST_CLEAR;
			clr_cnt_reg <= '0;
			method_reg <= CMSL_M_SLAVE;
			pullup_reg <= 1'b0;
			clr_reg <= 1'b1;
		end else begin
			state_reg <= state_next;
			clr_cnt_reg <= clr_cnt_next;
			method_reg <= method_next;
			pullup_reg <= pullup_next;
			clr_reg <= clr_next;
		end
	end
	logic serial_mode;
	assign serial_mode = (method_reg == CMSL_M_MASTER) || (method_reg == CMSL_M_SLAVE);
	// ==================================================================
	// Bit clock generator for master serial
	logic [DW-1:0] div_cnt_reg, div_cnt_next;
	logic cfg_bit_clock_reg, cfg_bit_clock_next;
	// Divide the system clock; runs in master mode while loading and after done, stopped while clearing
	always_comb begin
		div_cnt_next = div_cnt_reg;
		cfg_bit_clock_next = cfg_bit_clock_reg;
		if ((method_reg == CMSL_M_MASTER) && (state_reg != CMSL_ST_CLEAR)) begin
			if (div_cnt_reg == HALF_LAST_C) begin
				div_cnt_next = '0;
				cfg_bit_clock_next = ~cfg_bit_clock_reg;
			end else begin
				div_cnt_next = div_cnt_reg + DW'(1);
			end
		end else begin
			div_cnt_next = '0;
			cfg_bit_clock_next = 1'b0;
		end
	end
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			div_cnt_reg <= '0;
			cfg_bit_clock_reg <= 1'b0;
		end else begin
			div_cnt_reg <= div_cnt_next;
			cfg_bit_clock_reg <= cfg_bit_clock_next;
		end
	end
	// ==================================================================
	// Scan-port loading, open in every mode
	logic [CMSL_BYTE_W-1:0] sc_shift_reg, sc_shift_next;
	logic [2:0] sc_nbit_reg, sc_nbit_next;
	logic [CW-1:0] sc_count_reg, sc_count_next;
	logic sc_done_next;
	logic sc_byte_evt;
	always_comb begin
		sc_shift_next = sc_shift_reg;
		sc_nbit_next = sc_nbit_reg;
		sc_count_next = sc_count_reg;
		sc_done_next = sc_done_reg;
		sc_byte_evt = 1'b0;
		if (state_reg == CMSL_ST_CLEAR) begin
			sc_nbit_next = '0;
			sc_count_next = '0;
			sc_done_next = 1'b0;
		end else if ((state_reg == CMSL_ST_LOAD) && scan_bit_valid_i && !sc_done_reg) begin
			sc_shift_next = {sc_shift_reg[CMSL_BYTE_W-2:0], scan_bit_i};
			sc_nbit_next = sc_nbit_reg + 3'h1;
			sc_count_next = sc_count_reg + CW'(1);
			sc_byte_evt = (sc_nbit_reg == CMSL_NBIT_LAST);
			sc_done_next = (sc_count_next == CFG_BITS_C);
		end
	end
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			sc_shift_reg <= '0;
			sc_nbit_reg <= '0;
			sc_count_reg <= '0;
			sc_done_reg <= 1'b0;
		end else begin
			sc_shift_reg <= sc_shift_next;
			sc_nbit_reg <= sc_nbit_next;
			sc_count_reg <= sc_count_next;
			sc_done_reg <= sc_done_next;
		end
	end
	// ==================================================================
	// Link domain, clocked by the configuration bit clock
	// Reset asserts at once and releases on two link edges; the link clock may stop outside loading
	logic link_arst;
	logic lk_rst_meta_reg;
	logic lk_rst_reg;
	assign link_arst = rst_i | clr_reg;
	always_ff @(posedge cfg_bit_clock_i or posedge link_arst) begin
		if (link_arst) begin
			lk_rst_meta_reg <= 1'b1;
			lk_rst_reg <= 1'b1;
		end else begin
			lk_rst_meta_reg <= 1'b0;
			lk_rst_reg <= lk_rst_meta_reg;
		end
	end
	// Method register is steady whenever the link is out of reset, so it is read directly
	logic [CMSL_BYTE_W-1:0] lk_shift_reg, lk_shift_next;
	logic [2:0] lk_nbit_reg, lk_nbit_next;
	logic [CW-1:0] lk_count_reg, lk_count_next;
	logic lk_done_next;
	logic [CMSL_BYTE_W-1:0] lk_byte_reg, lk_byte_next;
	logic lk_tgl_next;
	logic lk_fwd_reg, lk_fwd_next;
	always_comb begin
		lk_shift_next = lk_shift_reg;
		lk_nbit_next = lk_nbit_reg;
		lk_count_next = lk_count_reg;
		lk_done_next = lk_done_reg;
		lk_byte_next = lk_byte_reg;
		lk_tgl_next = lk_tgl_reg;
		lk_fwd_next = lk_fwd_reg;
		if (lk_rst_reg) begin
			lk_nbit_next = '0;
			lk_count_next = '0;
			lk_done_next = 1'b0;
			lk_fwd_next = 1'b1;
		end else if (!lk_done_reg && serial_mode) begin
			// Bit taken on the rising edge, set up by the source beforehand
			lk_shift_next = {lk_shift_reg[CMSL_BYTE_W-2:0], ser_data_i};
			lk_nbit_next = lk_nbit_reg + 3'h1;
			lk_count_next = lk_count_reg + CW'(1);
			if (lk_nbit_reg == CMSL_NBIT_LAST) begin
				lk_byte_next = lk_shift_next;
				lk_tgl_next = ~lk_tgl_reg;
			end
			lk_done_next = (lk_count_next == CFG_BITS_C);
		end else if (!lk_done_reg && (method_reg == CMSL_M_BYTE) && byte_wr_en_i) begin
			lk_byte_next = byte_data_i;
			lk_tgl_next = ~lk_tgl_reg;
			lk_count_next = lk_count_reg + BYTE_STEP_C;
			lk_done_next = (lk_count_next >= CFG_BITS_C);
		end else if (lk_done_reg && serial_mode) begin
			// Downstream bits pass through, retimed on the rising edge
			lk_fwd_next = ser_data_i;
		end
	end
	// Cleared while clearing even with the link clock stopped, so a stale done cannot end the next load
	always_ff @(posedge cfg_bit_clock_i or posedge link_arst) begin
		if (link_arst) begin
			lk_shift_reg <= '0;
			lk_nbit_reg <= '0;
			lk_count_reg <= '0;
			lk_done_reg <= 1'b0;
			lk_byte_reg <= '0;
			lk_tgl_reg <= 1'b0;
			lk_fwd_reg <= 1'b1;
		end else begin
			lk_shift_reg <= lk_shift_next;
			lk_nbit_reg <= lk_nbit_next;
			lk_count_reg <= lk_count_next;
			lk_done_reg <= lk_done_next;
			lk_byte_reg <= lk_byte_next;
			lk_tgl_reg <= lk_tgl_next;
			lk_fwd_reg <= lk_fwd_next;
		end
	end
	// ==================================================================
	// Loaded byte stream out in the system domain
	// Link byte held eight bit clocks in serial modes and one in byte mode, longer than the three-cycle toggle crossing
	logic [CMSL_BYTE_W-1:0] byte_out_reg, byte_out_next;
	logic byte_valid_reg, byte_valid_next;
	// Link bytes win a same-cycle clash; scan and link loading are not expected together
	always_comb begin
		byte_out_next = byte_out_reg;
		byte_valid_next = 1'b0;
		if (lk_byte_evt && (state_reg != CMSL_ST_CLEAR)) begin
			byte_out_next = lk_byte_reg;
			byte_valid_next = 1'b1;
		end else if (sc_byte_evt) begin
			byte_out_next = sc_shift_next;
			byte_valid_next = 1'b1;
		end
	end
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			byte_out_reg <= '0;
			byte_valid_reg <= 1'b0;
		end else begin
			byte_out_reg <= byte_out_next;
			byte_valid_reg <= byte_valid_next;
		end
	end
	// ==================================================================
	// Outputs
	assign cfg_byte_o = byte_out_reg;
	assign cfg_byte_valid_o = byte_valid_reg;
	assign cfg_bit_clock_o = cfg_bit_clock_reg;
	assign cfg_bit_clock_oe_o = (method_reg == CMSL_M_MASTER) && (state_reg != CMSL_ST_CLEAR);
	assign ser_fwd_o = lk_fwd_reg;
	assign ser_fwd_oe_o = serial_mode && (state_reg != CMSL_ST_CLEAR);
	assign init_ready_o = (state_reg != CMSL_ST_CLEAR);
	assign done_o = (state_reg == CMSL_ST_DONE);
	assign load_method_o = method_reg;
	// Pull-ups only before loading completes, weak pull-downs afterwards
	assign io_pullup_en_o = pullup_reg && (state_reg != CMSL_ST_DONE);
	assign unused_io_pulldown_o = (state_reg == CMSL_ST_DONE);
	assign shared_pins_free_o = (state_reg == CMSL_ST_DONE);
endmodule
`default_nettype wire

// file: tb/cmsl_chk.sv
// Concurrent checks on the configuration loader's ports.
`default_nettype none
module cmsl_chk
	import cmsl_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic reconfig_req_n_i,
	input wire logic cfg_bit_clock_i,
	input wire logic cfg_bit_clock_oe_o,
	input wire logic ser_fwd_o,
	input wire logic ser_fwd_oe_o,
	input wire logic init_ready_o,
	input wire logic done_o,
	input wire logic [1:0] load_method_o,
	input wire logic io_pullup_en_o,
	input wire logic unused_io_pulldown_o,
	input wire logic shared_pins_free_o,
	input wire logic cfg_byte_valid_o
);
	default clocking @(posedge clk_i);
	endclocking
	default disable iff (rst_i);
	// =====
	// Pin directions follow the latched method
	property p_clk_oe; cfg_bit_clock_oe_o |-> load_method_o == CMSL_M_MASTER && init_ready_o; endproperty
	a_clk_oe: assert property (p_clk_oe) else $error("bit clock driven outside master");
	property p_fwd_oe; ser_fwd_oe_o |-> load_method_o inside {CMSL_M_MASTER, CMSL_M_SLAVE}; endproperty
	a_fwd_oe: assert property (p_fwd_oe) else $error("forward pin driven in byte or scan");
	// Forwarding stays idle until own load is over, then moves on link rises only
	property p_fwd_idle; init_ready_o && !done_o |-> ser_fwd_o; endproperty
	a_fwd_idle: assert property (p_fwd_idle) else $error("forward pin moved before done");
	property p_fwd_edge; init_ready_o && $changed(ser_fwd_o) |-> $rose(cfg_bit_clock_i); endproperty
	a_fwd_edge: assert property (p_fwd_edge) else $error("forward pin moved off a rising edge");
	// Pin states after loading
	property p_done_io; done_o |-> unused_io_pulldown_o && shared_pins_free_o && !io_pullup_en_o; endproperty
	a_done_io: assert property (p_done_io) else $error("io state wrong after done");
	// Latched choices must not follow the pins once loading runs
	property p_keep_mode; init_ready_o && $past(init_ready_o) |-> $stable(load_method_o); endproperty
	a_keep_mode: assert property (p_keep_mode) else $error("method changed during load");
	property p_keep_pull; init_ready_o && !done_o && $past(init_ready_o && !done_o) |-> $stable(io_pullup_en_o); endproperty
	a_keep_pull: assert property (p_keep_pull) else $error("pull-up option changed during load");
	// A held request keeps the device in its clearing state
	property p_req_clear; !reconfig_req_n_i [*4] |-> !init_ready_o && !done_o; endproperty
	a_req_clear: assert property (p_req_clear) else $error("request low but not clearing");
	property p_pulse; cfg_byte_valid_o |=> !cfg_byte_valid_o; endproperty
	a_pulse: assert property (p_pulse) else $error("byte strobe longer than one cycle");
	c_done: cover property ($rose(done_o));
	c_byte: cover property (cfg_byte_valid_o);
	c_mclk: cover property (cfg_bit_clock_oe_o && done_o);
endmodule
bind cmsl_loader cmsl_chk chk_u (.clk_i, .rst_i, .reconfig_req_n_i, .cfg_bit_clock_i, .cfg_bit_clock_oe_o,
	.ser_fwd_o, .ser_fwd_oe_o, .init_ready_o, .done_o, .load_method_o, .io_pullup_en_o,
	.unused_io_pulldown_o, .shared_pins_free_o, .cfg_byte_valid_o);
`default_nettype wire

// file: tb/cmsl_src.sv
// Configuration source model at the loader's link pins.
`default_nettype none
module cmsl_src (
	input wire logic link_i,
	output logic clk_o,
	output logic dat_o,
	output logic [7:0] byte_o,
	output logic wr_o
);
	timeunit 1ns;
	timeprecision 100ps;
	// =====
	// Clock stands low between beats
	initial begin
		clk_o = 1'b0;
		dat_o = 1'b0;
		byte_o = 8'h00;
		wr_o = 1'b0;
	end
	// One beat: data set in the low phase, held past the rise; half-ns phase never meets clk_i
	task automatic beat(input logic d, input logic [7:0] b, input logic w, input bit own);
		dat_o = d;
		byte_o = b;
		wr_o = w;
		if (own) begin
			#31.5 clk_o = 1'b1;
		end else begin
			@(posedge link_i);
		end
		// Released just after the rise, showing the inverse so stale data cannot pass
		#0.5;
		dat_o = ~d;
		byte_o = ~b;
		wr_o = 1'b0;
		if (own) begin
			#31.5 clk_o = 1'b0;
			#0.5;
		end else begin
			@(negedge link_i);
		end
	endtask
endmodule
`default_nettype wire

// file: tb/cmsl_loader_tb_top.sv
// Self-checking bench of the configuration loader.
`default_nettype none
module cmsl_loader_tb_top;
	import cmsl_pkg::*;
	timeunit 1ns;
	timeprecision 100ps;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic [2:0] mode = 3'h7;
	logic [2:0] drv = 3'h7;
	logic req_n = 1'b1;
	logic sb = 1'b0;
	logic sv = 1'b0;
	logic fwd_on = 1'b0;
	logic [31:0] seed = 32'h7a79;
	logic [1:0] cur;
	logic [7:0] exp_q [$];
	int n_mismatch = 0;
	int n_checks = 0;
	int cyc = 0;
	logic src_clk, src_dat, src_wr, link, ck_o, ck_oe, fwd, fwd_oe, rdy, done, pull, pdn, free, cval;
	logic [7:0] src_byte, cbyte;
	logic [1:0] meth;
	// =====
	// Design, source model and the shared bit clock wire
	assign link = ck_oe ? ck_o : src_clk;
	cmsl_loader #(.CFG_BITS(32), .INIT_CLR_CYC(2), .CFG_BIT_CLOCK_HALF_CYC(3)) dut_u (.clk_i(clk_i), .rst_i(rst_i),
		.mode_sel_bit2_i(mode[2]), .mode_sel_bit2_driven_i(drv[2]), .mode_sel_bit1_i(mode[1]),
		.mode_sel_bit1_driven_i(drv[1]), .mode_sel_bit0_i(mode[0]), .mode_sel_bit0_driven_i(drv[0]),
		.reconfig_req_n_i(req_n), .cfg_bit_clock_i(link), .cfg_bit_clock_o(ck_o), .cfg_bit_clock_oe_o(ck_oe),
		.ser_data_i(src_dat), .ser_fwd_o(fwd), .ser_fwd_oe_o(fwd_oe), .byte_data_i(src_byte),
		.byte_wr_en_i(src_wr), .scan_bit_i(sb), .scan_bit_valid_i(sv), .init_ready_o(rdy), .done_o(done),
		.load_method_o(meth), .io_pullup_en_o(pull), .unused_io_pulldown_o(pdn), .shared_pins_free_o(free),
		.cfg_byte_o(cbyte), .cfg_byte_valid_o(cval));
	cmsl_src src_u (.link_i(link), .clk_o(src_clk), .dat_o(src_dat), .byte_o(src_byte), .wr_o(src_wr));
	// Clock and cycle ceiling
	always #5 clk_i = ~clk_i;
	always @(posedge clk_i) begin
		cyc <= cyc + 1;
		if (cyc == 30000) begin
			n_mismatch++;
			wrap_up();
		end
	end
	// =====
	// Helpers
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	function automatic logic [1:0] exp_meth(input logic [2:0] c);
		case (c)
			3'h0, 3'h4: return CMSL_M_MASTER;
			3'h1, 3'h5: return CMSL_M_SCAN;
			3'h2, 3'h6: return CMSL_M_BYTE;
			default: return CMSL_M_SLAVE;
		endcase
	endfunction
	task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
		n_checks++;
		if (g !== e) begin
			n_mismatch++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic wrap_up();
		$display("Checks %0d mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	// Restart through the request pin and check the decoded pin roles
	task automatic start(input logic [2:0] c, input logic [2:0] d);
		logic [2:0] e;
		int t;
		e = c | ~d;
		cur = exp_meth(e);
		@(posedge clk_i);
		mode <= c;
		drv <= d;
		req_n <= 1'b0;
		repeat (4) @(posedge clk_i);
		req_n <= 1'b1;
		for (t = 0; t < 200 && rdy !== 1'b1; t++) @(negedge clk_i);
		chk("init_ready", 8'h1, {7'h0, rdy});
		chk("method", {6'h0, cur}, {6'h0, meth});
		chk("pullup", {7'h0, e inside {3'h4, 3'h1, 3'h2, 3'h3}}, {7'h0, pull});
		chk("fwd_oe", {7'h0, cur inside {CMSL_M_MASTER, CMSL_M_SLAVE}}, {7'h0, fwd_oe});
		chk("clk_oe", {7'h0, cur == CMSL_M_MASTER}, {7'h0, ck_oe});
	endtask
	// Wait for completion and check end state
	task automatic finish_chk();
		int t;
		for (t = 0; t < 60 && done !== 1'b1; t++) @(negedge clk_i);
		repeat (6) @(negedge clk_i);
		chk("done", 8'h1, {7'h0, done});
		chk("method", {6'h0, cur}, {6'h0, meth});
		chk("io_after", 8'h1, {7'h0, pdn & free});
		chk("left", 8'h0, 8'(exp_q.size()));
	endtask
	// Link load of four random bytes, pins flipped mid-way, then forwarded traffic for serial loads only
	task automatic load(input bit own, input bit byt);
		logic [7:0] b;
		int i, k;
		repeat (2) src_u.beat(1'b0, 8'h00, 1'b0, own);
		for (i = 0; i < 4; i++) begin
			seed = lfsr(seed);
			b = seed[7:0];
			exp_q.push_back(b);
			if (byt) src_u.beat(1'b0, b, 1'b1, own);
			else for (k = 7; k >= 0; k--) src_u.beat(b[k], 8'h00, 1'b0, own);
			if (i == 1) @(posedge clk_i) mode <= ~mode;
		end
		finish_chk();
		fwd_on = !byt;
		for (k = 0; k < 8 && !byt; k++) begin
			seed = lfsr(seed);
			src_u.beat(seed[0], 8'h00, 1'b0, own);
		end
		fwd_on = 1'b0;
	endtask
	// Scan-port load, back to back bits
	task automatic scan();
		logic [7:0] b;
		int i, k;
		for (i = 0; i < 4; i++) begin
			seed = lfsr(seed);
			b = seed[7:0];
			exp_q.push_back(b);
			for (k = 7; k >= 0; k--) begin
				@(posedge clk_i);
				sb <= b[k];
				sv <= 1'b1;
			end
		end
		@(posedge clk_i);
		sv <= 1'b0;
		sb <= ~sb;
		finish_chk();
	endtask
	// =====
	// Result watchers: loaded bytes against the queue, forwarded bits at each rise
	always @(negedge clk_i) if (cval === 1'b1) chk("cfg_byte", exp_q.size() > 0 ? exp_q.pop_front() : 8'hxx, cbyte);
	always @(posedge link) begin
		logic e;
		e = src_dat;
		#2;
		if (fwd_on) chk("fwd", {7'h0, e}, {7'h0, fwd});
	end
	// Main sequence
	initial begin
		int c;
		repeat (4) @(negedge clk_i);
		chk("rst_state", 8'h3, {6'h0, meth});
		chk("rst_fwd", 8'h1, {7'h0, fwd & ~rdy & ~done});
		@(posedge clk_i) rst_i <= 1'b0;
		for (c = 0; c < 8; c++) start(3'(c), 3'h7);
		start(3'h0, 3'h0);
		start(3'h7, 3'h7);
		load(1'b1, 1'b0);
		start(3'h6, 3'h7);
		load(1'b1, 1'b1);
		start(3'h0, 3'h7);
		load(1'b0, 1'b0);
		start(3'h6, 3'h7);
		scan();
		wrap_up();
	end
endmodule
`default_nettype wire
